// ==== common/dmf_pkg.sv ====
// Package of addresses, field positions and reset values for the data memory
// How it works
// - Byte-wide data memory, registers then RAM
// - Unused or reserved locations read zero
// - Addresses 00H and 02H redirect via pointers
// - Port reached by pointer: read zero, no write
// - Pointers are ordinary read/write storage
// - Single bits settable and clearable
// - Program counter low write jumps, dummy cycle
// - Table read high byte lands in table_high_byte
// - Writes never change halted or expiry flags
// - Carry flag from add, subtract, rotate
// - Nibble carry flag from low nibble
// - Zero flag tracks zero add, subtract or logic result
// - Overflow flag from carry in xor out
// - Halted flag: clear power-up/clear-dog, set halt
// - Expiry flag: clear power-up/clear/halt, set timeout
// - Flags never stacked automatically
// - Global enable cleared on entry, set on return
// - Separate independent interrupt enable bits
// - Moves go through working register only
// - Unused table high bits read zero
package dmf_pkg;
  localparam logic [7:0] ADDR_INDIRECT_PORT_0 = 8'h00;
  localparam logic [7:0] ADDR_POINTER_REG_0   = 8'h01;
  localparam logic [7:0] ADDR_INDIRECT_PORT_1 = 8'h02;
  localparam logic [7:0] ADDR_POINTER_REG_1   = 8'h03;
  localparam logic [7:0] ADDR_WORKING_REG     = 8'h05;
  localparam logic [7:0] ADDR_PC_LOW          = 8'h06;
  localparam logic [7:0] ADDR_TABLE_HIGH      = 8'h08;
  localparam logic [7:0] ADDR_FLAG_REG        = 8'h0a;
  localparam logic [7:0] ADDR_IRQ_CONTROL_0   = 8'h0b;
  localparam logic [7:0] ADDR_IRQ_CONTROL_1   = 8'h1e;
  localparam logic [7:0] ADDR_GP_BASE         = 8'h40;
  localparam logic [7:0] ADDR_GP_LAST         = 8'hff;
  // Flag register bit positions
  localparam int FLAG_CARRY  = 0;
  localparam int FLAG_NIBBLE = 1;
  localparam int FLAG_ZERO   = 2;
  localparam int FLAG_SIGNED = 3;
  localparam int FLAG_HALTED = 4;
  localparam int FLAG_EXPIRY = 5;
  localparam logic [7:0] FLAG_SW_MASK   = 8'h0f;
  localparam logic [7:0] FLAG_USED_MASK = 8'h3f;
  localparam int IRQ_GLOBAL_BIT = 0;
  localparam logic [7:0] IRQ_CONTROL_0_MASK = 8'hff;
  localparam logic [7:0] IRQ_CONTROL_1_MASK = 8'h77;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int TABLE_HIGH_BITS = 7;
  // ALU operation codes
  typedef enum logic [2:0] {
    ALU_NONE   = 3'h0,
    ALU_ADD    = 3'h1,
    ALU_SUB    = 3'h2,
    ALU_LOGIC  = 3'h3,
    ALU_ROTATE = 3'h4
  } dmf_alu_t;
endpackage

// ==== core/dmf_flag_unit.sv ====
// Arithmetic status flag evaluation for one ALU operation
module dmf_flag_unit (
  // Operation
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire dmf_pkg::dmf_alu_t aluOp,
  input  wire logic [7:0]       opA,
  input  wire logic [7:0]       opB,
  input  wire logic [7:0]       logicResult,
  input  wire logic             carryIn,
  input  wire logic             rotateLeft,
  input  wire logic [3:0]       flagsIn,
  // Result
  output logic [7:0]            result,
  output logic [3:0]            flagsOut
);
  logic [8:0] wide;
  logic [4:0] lowNib;
  logic [7:0] low7;
  always_comb begin
    wide     = 9'h000;
    lowNib   = 5'h00;
    low7     = 8'h00;
    result   = logicResult;
    flagsOut = flagsIn;
    unique case (aluOp)
      dmf_pkg::ALU_ADD, dmf_pkg::ALU_SUB: begin
        // Subtraction as a + ~b + 1, so carry out means no borrow
        if (aluOp == dmf_pkg::ALU_ADD) begin
          wide   = {1'b0, opA} + {1'b0, opB};
          lowNib = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
          low7   = {1'b0, opA[6:0]} + {1'b0, opB[6:0]};
        end else begin
          wide   = {1'b0, opA} + {1'b0, ~opB} + 9'h001;
          lowNib = {1'b0, opA[3:0]} + {1'b0, ~opB[3:0]} + 5'h01;
          low7   = {1'b0, opA[6:0]} + {1'b0, ~opB[6:0]} + 8'h01;
        end
        result = wide[7:0];
        flagsOut[dmf_pkg::FLAG_CARRY]  = wide[8];
        flagsOut[dmf_pkg::FLAG_NIBBLE] = lowNib[4];
        flagsOut[dmf_pkg::FLAG_SIGNED] = low7[7] ^ wide[8];
        flagsOut[dmf_pkg::FLAG_ZERO]   = (wide[7:0] == 8'h00);
      end
      dmf_pkg::ALU_LOGIC: begin
        flagsOut[dmf_pkg::FLAG_ZERO] = (logicResult == 8'h00);
      end
      dmf_pkg::ALU_ROTATE: begin
        if (rotateLeft) begin
          result = {opA[6:0], carryIn};
          flagsOut[dmf_pkg::FLAG_CARRY] = opA[7];
        end else begin
          result = {carryIn, opA[7:1]};
          flagsOut[dmf_pkg::FLAG_CARRY] = opA[0];
        end
      end
      default: begin
        result   = logicResult;
        flagsOut = flagsIn;
      end
    endcase
  end

  AST_ADD_CARRY: assert property (@(posedge clk) disable iff (sys_rst)
    aluOp == dmf_pkg::ALU_ADD |-> flagsOut[0] == ((9'(opA) + 9'(opB)) > 9'h0ff))
    else $error("carry flag wrong after add");
  AST_SUB_CARRY: assert property (@(posedge clk) disable iff (sys_rst)
    aluOp == dmf_pkg::ALU_SUB |-> flagsOut[0] == (opA >= opB))
    else $error("carry flag wrong after subtract");
  AST_NIBBLE: assert property (@(posedge clk) disable iff (sys_rst)
    aluOp == dmf_pkg::ALU_ADD |-> flagsOut[1] == ((5'(opA[3:0]) + 5'(opB[3:0])) > 5'h0f))
    else $error("nibble flag wrong after add");
  AST_SIGNED: assert property (@(posedge clk) disable iff (sys_rst)
    aluOp == dmf_pkg::ALU_ADD |->
      flagsOut[3] == ((opA[7] == opB[7]) && (result[7] != opA[7])))
    else $error("overflow flag wrong after add");
endmodule

// ==== core/dmf_data_memory.sv ====
// Data memory with special function registers and general purpose RAM
module dmf_data_memory #(
  parameter int GP_BASE = 8'h40
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Core access port
  input  wire logic [7:0]        memAddr,
  input  wire logic              memRead,
  input  wire logic              memWrite,
  input  wire logic [7:0]        memWdata,
  input  wire logic              bitSet,
  input  wire logic              bitClr,
  input  wire logic [2:0]        bitSel,
  output logic [7:0]             memRdata,
  // Working register load and ALU
  input  wire logic              workLoad,
  input  wire logic [7:0]        workData,
  input  wire dmf_pkg::dmf_alu_t aluOp,
  input  wire logic [7:0]        aluOperand,
  input  wire logic [7:0]        aluLogicResult,
  input  wire logic              aluToMem,
  input  wire logic              rotateLeft,
  output logic [7:0]             workingRegister,
  // Program counter and table read
  output logic                   pcLoad,
  output logic [7:0]             pcLowValue,
  output logic                   dummyCycle,
  input  wire logic              tableRead,
  input  wire logic [14:0]       tableWord,
  input  wire logic [7:0]        tableDest,
  // System events
  input  wire logic              haltInstr,
  input  wire logic              watchdogClearInstr,
  input  wire logic              watchdogTimeout,
  input  wire logic              irqEntry,
  input  wire logic              returnFromIrqInstr,
  output logic                   globalIrqEnable,
  output logic [7:0]             irqControl0,
  output logic [7:0]             irqControl1,
  output logic [7:0]             flagRegister
);
  localparam int GP_DEPTH = 256 - GP_BASE;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_DUMMY = 2'b10
  } dmf_state_t;

  logic [7:0] ram_q [GP_DEPTH];
  logic [7:0] ram_d [GP_DEPTH];
  logic [7:0] ptr0_q, ptr0_d, ptr1_q, ptr1_d;
  logic [7:0] work_q, work_d, table_high_byte_q, table_high_byte_d;
  logic [7:0] flag_q, flag_d, irq0_q, irq0_d, irq1_q, irq1_d;
  logic [7:0] pcl_q, pcl_d, rdata_q, rdata_d;
  logic       pcLoad_q, pcLoad_d;
  dmf_state_t state_q, state_d;
  logic [7:0] effAddr;
  logic       viaPtr, blocked, wrEn, rmw;
  logic [7:0] curVal, newVal, aluRes;
  logic [3:0] aluFlags;

  // Resolve indirect ports to the pointer contents
  function automatic logic isPort(input logic [7:0] a);
    return a == dmf_pkg::ADDR_INDIRECT_PORT_0 || a == dmf_pkg::ADDR_INDIRECT_PORT_1;
  endfunction

  function automatic logic [7:0] readAt(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a >= 8'(GP_BASE)) v = ram_q[a - 8'(GP_BASE)];
    else unique case (a)
      dmf_pkg::ADDR_POINTER_REG_0: v = ptr0_q;
      dmf_pkg::ADDR_POINTER_REG_1: v = ptr1_q;
      dmf_pkg::ADDR_WORKING_REG:   v = work_q;
      dmf_pkg::ADDR_PC_LOW:        v = pcl_q;
      dmf_pkg::ADDR_TABLE_HIGH:    v = table_high_byte_q;
      dmf_pkg::ADDR_FLAG_REG:      v = flag_q & dmf_pkg::FLAG_USED_MASK;
      dmf_pkg::ADDR_IRQ_CONTROL_0: v = irq0_q;
      dmf_pkg::ADDR_IRQ_CONTROL_1: v = irq1_q;
      default:                     v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    viaPtr  = isPort(memAddr);
    effAddr = memAddr;
    if (memAddr == dmf_pkg::ADDR_INDIRECT_PORT_0) effAddr = ptr0_q;
    if (memAddr == dmf_pkg::ADDR_INDIRECT_PORT_1) effAddr = ptr1_q;
    blocked = viaPtr && isPort(effAddr);
  end

  dmf_flag_unit u_flags (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .aluOp       (aluOp),
    .opA         (work_q),
    .opB         (aluOperand),
    .logicResult (aluLogicResult),
    .carryIn     (flag_q[dmf_pkg::FLAG_CARRY]),
    .rotateLeft  (rotateLeft),
    .flagsIn     (flag_q[3:0]),
    .result      (aluRes),
    .flagsOut    (aluFlags)
  );

  always_comb begin
    curVal  = blocked ? 8'h00 : readAt(effAddr);
    rmw     = bitSet || bitClr;
    newVal  = memWdata;
    if (aluToMem) newVal = aluRes;
    if (bitSet) newVal = curVal | (8'h01 << bitSel);
    if (bitClr) newVal = curVal & ~(8'h01 << bitSel);
    wrEn    = (memWrite || rmw || aluToMem) && !blocked && state_q == ST_RUN;
    rdata_d = memRead ? curVal : rdata_q;
    for (int i = 0; i < GP_DEPTH; i++) ram_d[i] = ram_q[i];
    ptr0_d = ptr0_q;
    ptr1_d = ptr1_q;
    work_d = work_q;
    table_high_byte_d = table_high_byte_q;
    flag_d = flag_q;
    irq0_d = irq0_q;
    irq1_d = irq1_q;
    pcl_d  = pcl_q;
    pcLoad_d = 1'b0;
    state_d  = ST_RUN;
    // ALU results land in the working register unless steered to memory
    if (aluOp != dmf_pkg::ALU_NONE && !aluToMem) work_d = aluRes;
    if (aluOp != dmf_pkg::ALU_NONE) flag_d[3:0] = aluFlags;
    if (workLoad) work_d = workData;
    if (wrEn) begin
      if (effAddr >= 8'(GP_BASE)) ram_d[effAddr - 8'(GP_BASE)] = newVal;
      else unique case (effAddr)
        dmf_pkg::ADDR_POINTER_REG_0: ptr0_d = newVal;
        dmf_pkg::ADDR_POINTER_REG_1: ptr1_d = newVal;
        dmf_pkg::ADDR_WORKING_REG:   work_d = newVal;
        dmf_pkg::ADDR_PC_LOW: begin
          pcl_d    = newVal;
          pcLoad_d = 1'b1;
          state_d  = ST_DUMMY;
        end
        // Halted and expiry bits keep their value on any write
        dmf_pkg::ADDR_FLAG_REG:
          flag_d = (flag_q & ~dmf_pkg::FLAG_SW_MASK) | (newVal & dmf_pkg::FLAG_SW_MASK);
        dmf_pkg::ADDR_IRQ_CONTROL_0: irq0_d = newVal & dmf_pkg::IRQ_CONTROL_0_MASK;
        dmf_pkg::ADDR_IRQ_CONTROL_1: irq1_d = newVal & dmf_pkg::IRQ_CONTROL_1_MASK;
        default: ;
      endcase
    end
    if (tableRead) begin
      table_high_byte_d = {1'b0, tableWord[14:8]};
      if (tableDest >= 8'(GP_BASE)) ram_d[tableDest - 8'(GP_BASE)] = tableWord[7:0];
    end
    // Status is never saved on interrupt entry or call
    if (irqEntry) irq0_d[dmf_pkg::IRQ_GLOBAL_BIT] = 1'b0;
    if (returnFromIrqInstr) irq0_d[dmf_pkg::IRQ_GLOBAL_BIT] = 1'b1;
    if (watchdogClearInstr) begin
      flag_d[dmf_pkg::FLAG_HALTED] = 1'b0;
      flag_d[dmf_pkg::FLAG_EXPIRY] = 1'b0;
    end
    if (haltInstr) begin
      flag_d[dmf_pkg::FLAG_HALTED] = 1'b1;
      flag_d[dmf_pkg::FLAG_EXPIRY] = 1'b0;
    end
    // Timeout set wins over a clear in the same cycle
    if (watchdogTimeout) flag_d[dmf_pkg::FLAG_EXPIRY] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < GP_DEPTH; i++) ram_q[i] <= dmf_pkg::RESET_BYTE;
      ptr0_q   <= dmf_pkg::RESET_BYTE;
      ptr1_q   <= dmf_pkg::RESET_BYTE;
      work_q   <= dmf_pkg::RESET_BYTE;
      table_high_byte_q   <= dmf_pkg::RESET_BYTE;
      flag_q   <= dmf_pkg::RESET_BYTE;
      irq0_q   <= dmf_pkg::RESET_BYTE;
      irq1_q   <= dmf_pkg::RESET_BYTE;
      pcl_q    <= dmf_pkg::RESET_BYTE;
      rdata_q  <= dmf_pkg::RESET_BYTE;
      pcLoad_q <= 1'b0;
      state_q  <= ST_RUN;
    end else begin
      for (int i = 0; i < GP_DEPTH; i++) ram_q[i] <= ram_d[i];
      ptr0_q   <= ptr0_d;
      ptr1_q   <= ptr1_d;
      work_q   <= work_d;
      table_high_byte_q   <= table_high_byte_d;
      flag_q   <= flag_d;
      irq0_q   <= irq0_d;
      irq1_q   <= irq1_d;
      pcl_q    <= pcl_d;
      rdata_q  <= rdata_d;
      pcLoad_q <= pcLoad_d;
      state_q  <= state_d;
    end
  end

  assign memRdata        = rdata_q;
  assign workingRegister = work_q;
  assign pcLoad          = pcLoad_q;
  assign pcLowValue      = pcl_q;
  assign dummyCycle      = (state_q == ST_DUMMY);
  assign globalIrqEnable = irq0_q[dmf_pkg::IRQ_GLOBAL_BIT];
  assign irqControl0     = irq0_q;
  assign irqControl1     = irq1_q;
  assign flagRegister    = flag_q & dmf_pkg::FLAG_USED_MASK;

  AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    memRead && !viaPtr && memAddr == 8'h04 |=> memRdata == 8'h00)
    else $error("unused location did not read zero");
  AST_PORT_LOOP: assert property (@(posedge clk) disable iff (sys_rst)
    memRead && blocked |=> memRdata == 8'h00)
    else $error("port reached by pointer did not read zero");
  AST_PTR_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    memWrite && memAddr == dmf_pkg::ADDR_INDIRECT_PORT_0 && ptr0_q >= 8'(GP_BASE)
      && !tableRead && state_q == ST_RUN && !bitSet && !bitClr && !aluToMem
      |=> ram_q[$past(ptr0_q) - 8'(GP_BASE)] == $past(memWdata))
    else $error("indirect write missed pointed location");
  AST_PCL_DUMMY: assert property (@(posedge clk) disable iff (sys_rst)
    wrEn && effAddr == dmf_pkg::ADDR_PC_LOW |=> pcLoad && dummyCycle ##1 !dummyCycle)
    else $error("program counter write without one dummy cycle");
  AST_TABLE_HIGH_BYTE: assert property (@(posedge clk) disable iff (sys_rst)
    tableRead |=> table_high_byte_q == {1'b0, $past(tableWord[14:8])})
    else $error("table high byte not captured");
  AST_FLAG_PROTECT: assert property (@(posedge clk) disable iff (sys_rst)
    wrEn && effAddr == dmf_pkg::ADDR_FLAG_REG && !haltInstr && !watchdogClearInstr
      && !watchdogTimeout |=> $stable(flag_q[5:4]))
    else $error("write altered protected flags");
  AST_HALT: assert property (@(posedge clk) disable iff (sys_rst)
    haltInstr && !watchdogTimeout |=> flag_q[4] && !flag_q[5])
    else $error("halt did not set halted and clear expiry");
  AST_TIMEOUT: assert property (@(posedge clk) disable iff (sys_rst)
    watchdogTimeout |=> flag_q[5])
    else $error("timeout did not set expiry flag");
  AST_IRQ_ENTRY: assert property (@(posedge clk) disable iff (sys_rst)
    irqEntry && !returnFromIrqInstr |=> !globalIrqEnable)
    else $error("global enable not cleared on entry");
  AST_RETURN: assert property (@(posedge clk) disable iff (sys_rst)
    returnFromIrqInstr |=> globalIrqEnable)
    else $error("global enable not set on return");

  COV_INDIRECT: cover property (@(posedge clk) memWrite && viaPtr && !blocked);
  COV_JUMP: cover property (@(posedge clk) pcLoad ##1 !dummyCycle);
  COV_TABLE: cover property (@(posedge clk) tableRead);
  COV_IRQ: cover property (@(posedge clk) irqEntry ##[1:20] returnFromIrqInstr);
endmodule

// ==== tb/dmf_core_model.sv ====
// Core-side model: issues accesses, ALU steps, table reads and system events
module dmf_core_model (
  // Clock and returned data
  input  wire logic         clk,
  input  wire logic [7:0]   memRdata,
  input  wire logic [7:0]   workingRegister,
  // Access port
  output logic [7:0]        memAddr = 8'h00,
  output logic              memRead = 1'b0,
  output logic              memWrite = 1'b0,
  output logic [7:0]        memWdata = 8'h00,
  output logic              bitSet = 1'b0,
  output logic              bitClr = 1'b0,
  output logic [2:0]        bitSel = 3'h0,
  // Working register and ALU
  output logic              workLoad = 1'b0,
  output logic [7:0]        workData = 8'h00,
  output dmf_pkg::dmf_alu_t aluOp = dmf_pkg::ALU_NONE,
  output logic [7:0]        aluOperand = 8'h00,
  output logic [7:0]        aluLogicResult = 8'h00,
  output logic              aluToMem = 1'b0,
  output logic              rotateLeft = 1'b0,
  // Table read and system events, halt down to return
  output logic              tableRead = 1'b0,
  output logic [14:0]       tableWord = 15'h0000,
  output logic [7:0]        tableDest = 8'h00,
  output logic [4:0]        events = 5'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // Extra idle cycles before each request, to pace the core slowly
  int slow = 0;

  task automatic go();
    repeat (slow + 1) @(posedge clk);
  endtask

  // Released data lines flip so a stale value never looks valid
  task automatic idle();
    @(posedge clk);
    memRead <= 1'b0;
    memWrite <= 1'b0;
    bitSet <= 1'b0;
    bitClr <= 1'b0;
    workLoad <= 1'b0;
    aluOp <= dmf_pkg::ALU_NONE;
    aluToMem <= 1'b0;
    tableRead <= 1'b0;
    events <= 5'h00;
    memWdata <= ~memWdata;
    workData <= ~workData;
  endtask

  // Optional second write follows at the very next edge
  task automatic wr(input logic [7:0] a, d, input logic two = 1'b0,
                    input logic [7:0] a2 = 8'h00, d2 = 8'h00);
    go();
    memAddr <= a;
    memWdata <= d;
    memWrite <= 1'b1;
    if (two) begin
      @(posedge clk);
      memAddr <= a2;
      memWdata <= d2;
    end
    idle();
  endtask

  task automatic rd(input logic [7:0] a);
    go();
    memAddr <= a;
    memRead <= 1'b1;
    idle();
  endtask

  task automatic bitop(input logic [7:0] a, input logic [2:0] s, input logic set);
    go();
    memAddr <= a;
    bitSel <= s;
    bitSet <= set;
    bitClr <= !set;
    idle();
  endtask

  task automatic ld(input logic [7:0] d);
    go();
    workData <= d;
    workLoad <= 1'b1;
    idle();
  endtask

  task automatic alu(input dmf_pkg::dmf_alu_t op, input logic [7:0] b, lr,
                     input logic rl, tm, input logic [7:0] a);
    go();
    aluOp <= op;
    aluOperand <= b;
    aluLogicResult <= lr;
    rotateLeft <= rl;
    aluToMem <= tm;
    memAddr <= a;
    idle();
  endtask

  task automatic tab(input logic [14:0] w, input logic [7:0] d);
    go();
    tableWord <= w;
    tableDest <= d;
    tableRead <= 1'b1;
    idle();
  endtask

  task automatic ev(input logic [4:0] e);
    go();
    events <= e;
    idle();
  endtask

  // No direct copy exists, so data goes through the working register
  task automatic move(input logic [7:0] s, d);
    rd(s);
    @(negedge clk);
    ld(memRdata);
    @(negedge clk);
    wr(d, workingRegister);
  endtask
endmodule

// ==== tb/tb.sv ====
// Bench for the data memory: core model drives it, read results are scoreboarded
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [7:0]        memAddr, memWdata, memRdata, workData, aluOperand, aluLogicResult;
  logic [7:0]        workingRegister, pcLowValue, tableDest, irqControl0, irqControl1;
  logic [7:0]        flagRegister;
  logic              memRead, memWrite, bitSet, bitClr, workLoad, aluToMem, rotateLeft;
  logic              pcLoad, dummyCycle, tableRead, globalIrqEnable;
  logic [2:0]        bitSel;
  logic [14:0]       tableWord;
  logic [4:0]        events;
  dmf_pkg::dmf_alu_t aluOp;
  logic [7:0]        expQ[$];
  logic              rdPend = 1'b0;
  int                fail_count = 0;
  int                tests_run = 0;
  int                seed = 61746;
  logic [3:0]        fl = 4'h0;
  dmf_pkg::dmf_alu_t opTab [4] = '{dmf_pkg::ALU_ADD, dmf_pkg::ALU_SUB,
                                   dmf_pkg::ALU_LOGIC, dmf_pkg::ALU_ROTATE};
  // Event pulse and flag byte expected after it
  logic [12:0]       evTab [4] = '{13'h042f, 13'h101f, 13'h043f, 13'h080f};

  always #20 clk = ~clk;

  dmf_data_memory #(.GP_BASE(64)) u_dmf_data_memory (
    .clk(clk), .sys_rst(sys_rst), .memAddr(memAddr), .memRead(memRead),
    .memWrite(memWrite), .memWdata(memWdata), .bitSet(bitSet), .bitClr(bitClr),
    .bitSel(bitSel), .memRdata(memRdata), .workLoad(workLoad), .workData(workData),
    .aluOp(aluOp), .aluOperand(aluOperand), .aluLogicResult(aluLogicResult),
    .aluToMem(aluToMem), .rotateLeft(rotateLeft), .workingRegister(workingRegister),
    .pcLoad(pcLoad), .pcLowValue(pcLowValue), .dummyCycle(dummyCycle),
    .tableRead(tableRead), .tableWord(tableWord), .tableDest(tableDest),
    .haltInstr(events[4]), .watchdogClearInstr(events[3]), .watchdogTimeout(events[2]),
    .irqEntry(events[1]), .returnFromIrqInstr(events[0]),
    .globalIrqEnable(globalIrqEnable), .irqControl0(irqControl0),
    .irqControl1(irqControl1), .flagRegister(flagRegister));

  dmf_core_model u_dmf_core_model (
    .clk(clk), .memRdata(memRdata), .workingRegister(workingRegister),
    .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite), .memWdata(memWdata),
    .bitSet(bitSet), .bitClr(bitClr), .bitSel(bitSel), .workLoad(workLoad),
    .workData(workData), .aluOp(aluOp), .aluOperand(aluOperand),
    .aluLogicResult(aluLogicResult), .aluToMem(aluToMem), .rotateLeft(rotateLeft),
    .tableRead(tableRead), .tableWord(tableWord), .tableDest(tableDest),
    .events(events));

  task automatic cmp(input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk(input logic [7:0] a, e);
    expQ.push_back(e);
    u_dmf_core_model.rd(a);
  endtask

  task automatic flags(input logic [7:0] e);
    chk(dmf_pkg::ADDR_FLAG_REG, e);
    cmp(flagRegister, e);
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Returns {flags, result}; flags are {signed, zero, nibble, carry}
  function automatic logic [11:0] aluRef(input dmf_pkg::dmf_alu_t op,
      input logic [7:0] a, b, lr, input logic [3:0] f, input logic rl);
    logic       sub;
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] k;
    logic [7:0] r;
    logic [3:0] o;
    sub = (op == dmf_pkg::ALU_SUB);
    bb = sub ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
    n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
    k = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, sub};
    r = s[7:0];
    o = {k[7] ^ s[8], s[7:0] == 8'h00, n[4], s[8]};
    if (op == dmf_pkg::ALU_LOGIC) begin
      r = lr;
      o = {f[3], lr == 8'h00, f[1:0]};
    end else if (op == dmf_pkg::ALU_ROTATE) begin
      r = rl ? {a[6:0], f[0]} : {f[0], a[7:1]};
      o = {f[3:1], rl ? a[7] : a[0]};
    end
    return {o, r};
  endfunction

  // Read data lands the cycle after the read is taken
  always @(posedge clk) begin
    rdPend <= memRead;
    if (rdPend && expQ.size() > 0) begin
      cmp(memRdata, expQ.pop_front());
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    $display("Watchdog expired at %0t", $time);
    summarize();
  end

  initial begin
    logic [7:0]  a, b, d, p;
    logic [11:0] r;
    logic [14:0] w;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    chk(dmf_pkg::ADDR_GP_LAST, 8'h00);
    flags(8'h00);
    for (int i = 0; i < 4; i++) begin
      // Both RAM ends, one unused register slot and one reserved gap address
      a = (i == 0) ? dmf_pkg::ADDR_GP_BASE : (i == 1) ? dmf_pkg::ADDR_GP_LAST :
          (i == 2) ? 8'h04 : 8'h25;
      d = 8'($random(seed)) | 8'h01;
      u_dmf_core_model.wr(a, d);
      chk(a, (i < 2) ? d : 8'h00);
    end
    for (int i = 0; i < 2; i++) begin
      p = 8'h80 | 8'($random(seed));
      d = 8'($random(seed));
      u_dmf_core_model.wr(8'(2 * i + 1), p);
      u_dmf_core_model.wr(8'(2 * i), d);
      chk(p, d);
      chk(8'(2 * i), d);
      chk(8'(2 * i + 1), p);
      u_dmf_core_model.wr(8'(2 * i + 1), 8'(2 - 2 * i));
      u_dmf_core_model.wr(8'(2 * i), ~d);
      chk(8'(2 * i), 8'h00);
    end
    d = 8'($random(seed));
    u_dmf_core_model.wr(dmf_pkg::ADDR_PC_LOW, d);
    #1;
    cmp({6'h00, pcLoad, dummyCycle}, 8'h03);
    cmp(pcLowValue, d);
    @(posedge clk);
    #1;
    cmp({6'h00, pcLoad, dummyCycle}, 8'h00);
    u_dmf_core_model.wr(dmf_pkg::ADDR_PC_LOW, d, 1'b1, 8'h44, 8'h5a);
    chk(8'h44, 8'h00);
    w = 15'($random(seed));
    u_dmf_core_model.tab(w, 8'h42);
    chk(dmf_pkg::ADDR_TABLE_HIGH, {1'b0, w[14:8]});
    chk(8'h42, w[7:0]);
    u_dmf_core_model.wr(dmf_pkg::ADDR_FLAG_REG, 8'hff);
    flags(8'h0f);
    foreach (evTab[i]) begin
      u_dmf_core_model.ev(evTab[i][12:8]);
      flags(evTab[i][7:0]);
    end
    fl = 4'hf;
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 8'h7f : 8'($random(seed));
      b = (i == 0) ? 8'h01 : (i == 1) ? a : 8'($random(seed));
      d = (i == 2) ? 8'h00 : 8'($random(seed));
      u_dmf_core_model.ld(a);
      u_dmf_core_model.alu(opTab[i % 4], b, d, i[2], 1'b0, 8'h00);
      r = aluRef(opTab[i % 4], a, b, d, fl, i[2]);
      fl = r[11:8];
      chk(dmf_pkg::ADDR_WORKING_REG, r[7:0]);
      flags({4'h0, fl});
    end
    u_dmf_core_model.ld(8'h10);
    u_dmf_core_model.alu(dmf_pkg::ALU_ADD, 8'h05, 8'h00, 1'b0, 1'b1, 8'h43);
    r = aluRef(dmf_pkg::ALU_ADD, 8'h10, 8'h05, 8'h00, fl, 1'b0);
    fl = r[11:8];
    chk(8'h43, r[7:0]);
    chk(dmf_pkg::ADDR_WORKING_REG, 8'h10);
    u_dmf_core_model.wr(dmf_pkg::ADDR_IRQ_CONTROL_1, 8'hff);
    chk(dmf_pkg::ADDR_IRQ_CONTROL_1, 8'h77);
    u_dmf_core_model.bitop(dmf_pkg::ADDR_IRQ_CONTROL_0, 3'h0, 1'b1);
    u_dmf_core_model.bitop(dmf_pkg::ADDR_IRQ_CONTROL_0, 3'h5, 1'b1);
    chk(dmf_pkg::ADDR_IRQ_CONTROL_0, 8'h21);
    cmp({7'h00, globalIrqEnable}, 8'h01);
    u_dmf_core_model.ev(5'h02);
    #1;
    cmp({7'h00, globalIrqEnable}, 8'h00);
    chk(dmf_pkg::ADDR_IRQ_CONTROL_0, 8'h20);
    flags({4'h0, fl});
    u_dmf_core_model.ev(5'h01);
    #1;
    cmp({7'h00, globalIrqEnable}, 8'h01);
    // Slow pacing from here on
    u_dmf_core_model.slow = 2;
    u_dmf_core_model.wr(8'h41, 8'h0f);
    u_dmf_core_model.bitop(8'h41, 3'h7, 1'b1);
    u_dmf_core_model.bitop(8'h41, 3'h0, 1'b0);
    expQ.push_back(8'h8e);
    u_dmf_core_model.move(8'h41, 8'h45);
    chk(8'h45, 8'h8e);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule
